// [core/arc_accumulator_and_region_checker.sv]
`timescale 1ns/1ps
// What this block does
// - double float: first accumulator, 4x64 channels
// - float: either general accumulator, 8x32 channels
// - no accumulator for quadword or byte types
// - dword integer: 8 channels of 64-bit values
// - word integer: 16 channels of 33 bits
// - eight 256-bit special accumulators, two to nine
// - special accumulator keeps low two bits per dword
// - implicit special access only in four-component mode
// - selector 1..7 picks three..nine, 8 means none
// - first source row's last element must start within its register
// - byte destination may use even or odd bytes
// - word destination may use even or odd words
// - implicit writes need bit, enable, channel mask
module arc_accumulator_and_region_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire arc_pkg::arc_instr_t instr,
    input wire arc_pkg::arc_region_t src0,
    input wire arc_pkg::arc_region_t src1,
    input wire arc_pkg::arc_region_t dst,
    input wire logic accumulator_disable,
    input wire logic [15:0] channel_enable,
    input wire logic [255:0] implicit_data,
    input wire logic special_wr,
    input wire logic [2:0] special_index,
    input wire logic [255:0] special_wdata,
    input wire logic special_implicit_wr,
    input wire logic [7:0] special_selector,
    input wire logic [2:0] special_rd_index,
    output logic [255:0] special_rdata,
    output logic [527:0] first_general_accumulator,
    output logic [255:0] second_general_accumulator,
    output logic illegal,
    output logic [4:0] illegal_cause
);
    // ************************************************************
    // general accumulators
    // ************************************************************
    // word mode needs 16 channels of 33 bits, wider than 512
    logic [arc_pkg::W_CHANNELS*arc_pkg::W_CH_BITS-1:0] first_general_accumulator_q;
    logic [255:0] second_general_accumulator_q;
    logic wr_en;
    arc_pkg::arc_type_t et;

    assign et = instr.exec_type;
    assign wr_en = instr_valid && instr.accumulator_write_bit
        && !accumulator_disable;

    // per-type channel packing; disabled channels keep old bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_general_accumulator_q <= '0;
            second_general_accumulator_q <= '0;
        end else if (wr_en) begin
            case (et)
                arc_pkg::ARC_T_DOUBLE_FLOAT: begin
                    for (int c = 0; c < arc_pkg::DF_CHANNELS; c++) begin
                        if (channel_enable[c])
                            first_general_accumulator_q[c*64 +: 64] <= implicit_data[c*64 +: 64];
                    end
                end
                arc_pkg::ARC_T_FLOAT: begin
                    for (int c = 0; c < arc_pkg::F_CHANNELS; c++) begin
                        if (channel_enable[c] && instr.acc_index[0])
                            second_general_accumulator_q[c*32 +: 32] <= implicit_data[c*32 +: 32];
                        else if (channel_enable[c])
                            first_general_accumulator_q[c*32 +: 32] <= implicit_data[c*32 +: 32];
                    end
                end
                arc_pkg::ARC_T_DWORD_INT,
                arc_pkg::ARC_T_UNSIGNED_DOUBLEWORD: begin
                    for (int c = 0; c < arc_pkg::D_CHANNELS; c++) begin
                        if (channel_enable[c])
                            first_general_accumulator_q[c*64 +: 64] <= {
                                {32{implicit_data[c*32+31]
                                    && et == arc_pkg::ARC_T_DWORD_INT}},
                                implicit_data[c*32 +: 32]};
                    end
                end
                arc_pkg::ARC_T_WORD_INT,
                arc_pkg::ARC_T_UNSIGNED_WORD: begin
                    for (int c = 0; c < arc_pkg::W_CHANNELS; c++) begin
                        if (channel_enable[c])
                            first_general_accumulator_q[c*33 +: 33] <= {
                                {17{implicit_data[c*16+15]
                                    && et == arc_pkg::ARC_T_WORD_INT}},
                                implicit_data[c*16 +: 16]};
                    end
                end
                // quadword and byte types have no storage
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_general_accumulator <= '0;
            second_general_accumulator <= '0;
        end else begin
            first_general_accumulator <= first_general_accumulator_q;
            second_general_accumulator <= second_general_accumulator_q;
        end
    end

    // ************************************************************
    // special accumulators, only the low bits of each dword held
    // ************************************************************
    logic [1:0] spec_q [arc_pkg::SPECIAL_COUNT][arc_pkg::SPECIAL_DWORDS];
    logic impl_hit;
    logic [2:0] impl_idx;

    // selector 1..7 maps to entries 1..7 (three..nine)
    assign impl_hit = special_implicit_wr
        && instr.four_component_access_mode
        && special_selector >= arc_pkg::SEL_FIRST
        && special_selector <= arc_pkg::SEL_LAST;
    assign impl_idx = special_selector[2:0];

    generate
        for (genvar a = 0; a < arc_pkg::SPECIAL_COUNT; a++) begin : g_spec
            for (genvar d = 0; d < arc_pkg::SPECIAL_DWORDS; d++) begin : g_dw
                always_ff @(posedge clk or negedge rst_n) begin
                    if (!rst_n)
                        spec_q[a][d] <= 2'h0;
                    else if (impl_hit && impl_idx == 3'(a))
                        spec_q[a][d] <= implicit_data[d*32 +: 2];
                    else if (special_wr && special_index == 3'(a))
                        spec_q[a][d] <= special_wdata[d*32 +: 2];
                end
            end
        end
    endgenerate

    // undefined upper bits read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            special_rdata <= '0;
        end else begin
            for (int d = 0; d < arc_pkg::SPECIAL_DWORDS; d++)
                special_rdata[d*32 +: 32] <= {30'h0,
                    spec_q[special_rd_index][d]};
        end
    end

    // ************************************************************
    // region legality
    // ************************************************************
    function automatic logic region_bad(arc_pkg::arc_region_t r,
            logic [5:0] es, logic is_dst);
        logic bad;
        logic [11:0] row_end;
        logic [11:0] span;
        logic [3:0] eb;
        bad = 1'b0;
        eb = arc_pkg::arc_type_bytes(r.data_type);
        if (r.used && !is_dst) begin
            if (es < r.width)
                bad = 1'b1;
            if (es == r.width && r.horizontal_stride != 6'h0
                    && 12'(r.vertical_stride) !=
                    12'(r.width) * 12'(r.horizontal_stride))
                bad = 1'b1;
            if (r.width == 6'h1 && r.horizontal_stride != 6'h0)
                bad = 1'b1;
            if (es == 6'h1 && r.width == 6'h1
                    && r.vertical_stride != 6'h0)
                bad = 1'b1;
            if (r.vertical_stride == 6'h0 && r.horizontal_stride == 6'h0
                    && r.width != 6'h1)
                bad = 1'b1;
            row_end = 12'(r.sub_offset) + (12'(r.width) - 12'h1)
                * 12'(r.horizontal_stride) * 12'(eb);
            if (r.width != 6'h0 && (row_end >> 5) != 12'h0)
                bad = 1'b1;
        end
        if (r.used && is_dst && r.horizontal_stride == 6'h0)
            bad = 1'b1;
        span = 12'(r.sub_offset) + 12'(es) * 12'(eb)
            * ((is_dst || r.width == 6'h0) ? 12'(r.horizontal_stride)
            : 12'h1);
        if (r.used && span > 12'(arc_pkg::MAX_SPAN_REGS
                * arc_pkg::GRF_BYTES))
            bad = 1'b1;
        return bad;
    endfunction

    logic [4:0] cause_d;
    logic [3:0] nmax, db, xb;
    logic wide_op;

    always_comb begin
        cause_d = 5'h0;
        db = arc_pkg::arc_type_bytes(dst.data_type);
        xb = arc_pkg::arc_type_bytes(et);
        nmax = db;
        if (src0.used && arc_pkg::arc_type_bytes(src0.data_type) > nmax)
            nmax = arc_pkg::arc_type_bytes(src0.data_type);
        if (src1.used && arc_pkg::arc_type_bytes(src1.data_type) > nmax)
            nmax = arc_pkg::arc_type_bytes(src1.data_type);
        wide_op = db == 4'h8 || nmax == 4'h8 || instr.dword_multiply;
        if (10'(instr.execution_size) * 10'(nmax)
                > 10'(arc_pkg::MAX_EXEC_BYTES))
            cause_d[0] = 1'b1;
        // even/odd offset within channel accepted for byte/word
        if (xb > db && (12'(dst.horizontal_stride) != 12'(xb / db)
                || (dst.sub_offset % 5'(xb)) >= 5'(db * 4'h2)))
            cause_d[1] = 1'b1;
        if (region_bad(src0, instr.execution_size, 1'b0)
                || region_bad(src1, instr.execution_size, 1'b0)
                || region_bad(dst, instr.execution_size, 1'b1))
            cause_d[2] = 1'b1;
        if (db == 4'h1 && dst.horizontal_stride == 6'h1 && !instr.raw_copy)
            cause_d[3] = 1'b1;
        if (wide_op && (instr.indirect
                || instr.uses_architecture_register_file
                || instr.dependency_control_hint))
            cause_d[4] = 1'b1;
        if (wide_op && !instr.four_component_access_mode && src0.used
                && src0.width != 6'h1
                && (12'(src0.vertical_stride) != 12'(src0.width)
                * 12'(src0.horizontal_stride)
                || src0.sub_offset != dst.sub_offset))
            cause_d[4] = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            illegal <= 1'b0;
            illegal_cause <= 5'h0;
        end else begin
            illegal <= instr_valid && (cause_d != 5'h0);
            illegal_cause <= instr_valid ? cause_d : 5'h0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_noacc;
        @(posedge clk) disable iff (!rst_n)
        (special_implicit_wr && special_selector == arc_pkg::SEL_NOACC)
        |=> $stable(spec_q[1][0]) && $stable(spec_q[7][0]);
    endproperty
    a_noacc: assert property (p_noacc)
        else $error("noacc selector changed a special accumulator");

    property p_disabled_keeps;
        @(posedge clk) disable iff (!rst_n)
        (accumulator_disable || !instr_valid) |=> $stable(first_general_accumulator_q);
    endproperty
    a_disabled_keeps: assert property (p_disabled_keeps)
        else $error("accumulator changed while writes disabled");

    property p_illegal_dst;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && dst.used && dst.horizontal_stride == 6'h0)
        |=> illegal;
    endproperty
    a_illegal_dst: assert property (p_illegal_dst)
        else $error("zero destination stride not flagged");

    property p_byte_packed;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && db == 4'h1 && dst.horizontal_stride == 6'h1
            && !instr.raw_copy) |=> illegal_cause[3];
    endproperty
    a_byte_packed: assert property (p_byte_packed)
        else $error("packed byte destination not flagged");

    property p_spec_write;
        @(posedge clk) disable iff (!rst_n)
        (special_wr && !impl_hit && special_index == 3'h2)
        |=> spec_q[2][0] == $past(special_wdata[1:0]);
    endproperty
    a_spec_write: assert property (p_spec_write)
        else $error("special accumulator write lost low bits");

    property p_exec_bytes;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && 10'(instr.execution_size) * 10'(db)
            > 10'(arc_pkg::MAX_EXEC_BYTES)) |=> illegal_cause[0];
    endproperty
    a_exec_bytes: assert property (p_exec_bytes)
        else $error("execution bytes above limit not flagged");

    property p_wide_hint;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && (instr.dword_multiply || db == 4'h8)
            && instr.dependency_control_hint) |=> illegal_cause[4];
    endproperty
    a_wide_hint: assert property (p_wide_hint)
        else $error("dependency hint on wide op not flagged");

    property p_quiet;
        @(posedge clk) disable iff (!rst_n)
        !instr_valid |=> !illegal && illegal_cause == 5'h0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("illegal raised with no instruction");
endmodule // arc_accumulator_and_region_checker

// [core/arc_pkg.sv]
package arc_pkg;
    // ************************************************************
    // operand element types
    // ************************************************************
    typedef enum logic [3:0] {
        ARC_T_DOUBLE_FLOAT,
        ARC_T_FLOAT,
        ARC_T_HALF_FLOAT,
        ARC_T_QUAD_INT,
        ARC_T_DWORD_INT,
        ARC_T_UNSIGNED_DOUBLEWORD,
        ARC_T_WORD_INT,
        ARC_T_UNSIGNED_WORD,
        ARC_T_BYTE_INT,
        ARC_T_UNSIGNED_BYTE
    } arc_type_t;

    // ************************************************************
    // accumulator layout
    // ************************************************************
    localparam int ACC_BITS = 256;
    localparam int DF_CHANNELS = 4;
    localparam int DF_CH_BITS = 64;
    localparam int F_CHANNELS = 8;
    localparam int F_CH_BITS = 32;
    localparam int D_CHANNELS = 8;
    localparam int D_CH_BITS = 64;
    localparam int W_CHANNELS = 16;
    localparam int W_CH_BITS = 33;
    localparam int SPECIAL_COUNT = 8;
    localparam int SPECIAL_DWORDS = 8;
    localparam int SPECIAL_VALID_BITS = 2;
    localparam int MAX_EXEC_BYTES = 64;
    localparam int GRF_BYTES = 32;
    localparam int MAX_SPAN_REGS = 2;
    localparam logic [7:0] SEL_FIRST = 8'h01;
    localparam logic [7:0] SEL_LAST = 8'h07;
    localparam logic [7:0] SEL_NOACC = 8'h08;
    localparam logic [63:0] RESET_WORD = 64'h0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [5:0] vertical_stride;
        logic [5:0] width;
        logic [5:0] horizontal_stride;
        logic [4:0] sub_offset;
        logic [7:0] reg_num;
        arc_type_t data_type;
        logic used;
    } arc_region_t;

    typedef struct packed {
        logic [5:0] execution_size;
        arc_type_t exec_type;
        logic raw_copy;
        logic four_component_access_mode;
        logic dword_multiply;
        logic indirect;
        logic uses_architecture_register_file;
        logic dependency_control_hint;
        logic accumulator_write_bit;
        logic [1:0] acc_index;
    } arc_instr_t;

    function automatic logic [3:0] arc_type_bytes(arc_type_t t);
        case (t)
            ARC_T_DOUBLE_FLOAT, ARC_T_QUAD_INT: return 4'h8;
            ARC_T_FLOAT, ARC_T_DWORD_INT,
            ARC_T_UNSIGNED_DOUBLEWORD: return 4'h4;
            ARC_T_HALF_FLOAT, ARC_T_WORD_INT,
            ARC_T_UNSIGNED_WORD: return 4'h2;
            default: return 4'h1;
        endcase
    endfunction
endpackage

// [tb/arc_issue_model.sv]
`timescale 1ns/1ps
// ************************************************************
// issue side: hands one instruction with src0, src1 and dst descriptors per call
// ************************************************************
module arc_issue_model (
    input wire logic clk,
    output logic instr_valid,
    output arc_pkg::arc_instr_t instr,
    output arc_pkg::arc_region_t src0,
    output arc_pkg::arc_region_t src1,
    output arc_pkg::arc_region_t dst
);
    initial begin
        instr_valid = 1'b0;
        instr = '0;
        src0 = '0;
        src1 = '0;
        dst = '0;
    end

    // codes 0 and 14..16 are legal descriptors; codes 1..13 each break one rule, codes 1 and 8 break two
    task automatic send(input int code, input arc_pkg::arc_type_t t,
        input logic [1:0] ai, input logic aw, input logic fc);
        arc_pkg::arc_instr_t i;
        arc_pkg::arc_region_t s;
        arc_pkg::arc_region_t s1;
        arc_pkg::arc_region_t d;
        i = '0; // no modifiers, raw copy off unless asked
        i.execution_size = 6'h04; // 4 lanes of at most 8 bytes
        i.exec_type = t;
        i.four_component_access_mode = fc;
        i.accumulator_write_bit = aw;
        i.acc_index = ai;
        s = '0;
        s.used = 1'b1;
        s.data_type = t;
        s.reg_num = 8'h0a;
        s.vertical_stride = 6'h04;
        s.width = 6'h04;
        s.horizontal_stride = 6'h01;
        s1 = s;
        d = s;
        d.reg_num = 8'h14;
        case (code)
            1: i.execution_size = 6'h10;
            2: d.horizontal_stride = 6'h00;
            3: begin
                s.width = 6'h01;
                s.vertical_stride = 6'h01;
            end
            4: begin
                s.width = 6'h08;
                s.vertical_stride = 6'h08;
            end
            5: s.vertical_stride = 6'h02;
            6: s.sub_offset = 5'h18;
            7: begin
                i.execution_size = 6'h08;
                s.width = 6'h08;
                s.horizontal_stride = 6'h04;
                s.vertical_stride = 6'h20;
            end
            8: d.data_type = arc_pkg::ARC_T_BYTE_INT;
            9: d.data_type = arc_pkg::ARC_T_WORD_INT;
            10: i.indirect = 1'b1;
            11: i.uses_architecture_register_file = 1'b1;
            12: i.dependency_control_hint = 1'b1;
            13: s.width = 6'h02;
            14: i.raw_copy = 1'b1;
            15: begin
                d.data_type = arc_pkg::ARC_T_BYTE_INT;
                d.horizontal_stride = 6'h02;
                d.sub_offset = 5'h01;
            end
            16: begin
                d.data_type = arc_pkg::ARC_T_HALF_FLOAT;
                d.horizontal_stride = 6'h02;
                d.sub_offset = 5'h02;
            end
            default: ;
        endcase
        instr_valid <= 1'b1;
        instr <= i;
        src0 <= s;
        src1 <= s1;
        dst <= d;
        @(posedge clk);
        instr_valid <= 1'b0;
    endtask
endmodule // arc_issue_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk;
    logic rst_n;
    logic instr_valid;
    arc_pkg::arc_instr_t instr;
    arc_pkg::arc_region_t src0;
    arc_pkg::arc_region_t src1;
    arc_pkg::arc_region_t dst;
    logic accumulator_disable;
    logic [15:0] channel_enable;
    logic [255:0] implicit_data;
    logic [255:0] special_wdata;
    logic [255:0] special_rdata;
    logic [255:0] sga;
    logic [527:0] fga;
    logic special_wr;
    logic special_implicit_wr;
    logic [2:0] special_index;
    logic [2:0] special_rd_index;
    logic [7:0] special_selector;
    logic illegal;
    logic [4:0] illegal_cause;
    int bad_count = 0;
    int checks_done = 0;
    int tn[17] = '{1, 0, 1, 1, 1, 1, 1, 1, 6, 4, 0, 0, 0, 0, 9, 6, 1};
    int ex[17] = '{-1, 0, 2, 2, 2, 2, 2, 2, 3, 1, 4, 4, 4, 4, -1, -1, -1};
    localparam logic [255:0] PA = {128'h88888888_77777777_66666666_55555555,
        128'h44444444_33333333_22222222_81111111};
    localparam logic [255:0] PB = {8{32'habababab}};

    arc_issue_model issue (.clk(clk), .instr_valid(instr_valid),
        .instr(instr), .src0(src0), .src1(src1), .dst(dst));

    arc_accumulator_and_region_checker dut (.clk(clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr(instr), .src0(src0),
        .src1(src1), .dst(dst), .accumulator_disable(accumulator_disable),
        .channel_enable(channel_enable), .implicit_data(implicit_data),
        .special_wr(special_wr), .special_index(special_index),
        .special_wdata(special_wdata),
        .special_implicit_wr(special_implicit_wr),
        .special_selector(special_selector),
        .special_rd_index(special_rd_index), .special_rdata(special_rdata),
        .first_general_accumulator(fga), .second_general_accumulator(sga),
        .illegal(illegal), .illegal_cause(illegal_cause));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [511:0] got, input logic [511:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // entry pattern; m keeps only the two bits per dword that survive
    function automatic logic [255:0] wd(input int i, input logic m);
        logic [255:0] r;
        for (int j = 0; j < 8; j++)
            r[32*j+:32] = {m ? 30'h0 : 30'h3fffffff, 2'(i >> (j % 2))};
        return r;
    endfunction

    task automatic acc(input int t, input logic [1:0] ai,
        input logic [255:0] v, input logic [15:0] en, input logic ds,
        input logic aw);
        @(posedge clk);
        implicit_data <= v;
        channel_enable <= en;
        accumulator_disable <= ds;
        issue.send(0, arc_pkg::arc_type_t'(4'(t)), ai, aw, 1'b0);
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic sp_rd(input int i, input logic [255:0] e);
        @(posedge clk);
        special_rd_index <= 3'(i);
        repeat (2) @(posedge clk);
        #1;
        chk({256'h0, special_rdata}, {256'h0, e});
    endtask

    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        accumulator_disable = 1'b0;
        channel_enable = 16'hffff;
        implicit_data = '0;
        special_wr = 1'b0;
        special_index = 3'h0;
        special_wdata = '0;
        special_implicit_wr = 1'b0;
        special_selector = 8'h00;
        special_rd_index = 3'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 17; k++) begin
            @(posedge clk);
            issue.send(k, arc_pkg::arc_type_t'(4'(tn[k])), 2'h0, 1'b0, 1'b0);
            #1;
            chk(512'(illegal), 512'(ex[k] >= 0));
            if (ex[k] >= 0 && ex[k] < 5)
                chk(512'(illegal_cause[ex[k]]), 512'h1);
        end
        acc(1, 2'h0, PA, 16'hffff, 1'b0, 1'b1);
        chk(512'(fga[255:0]), 512'(PA));
        acc(1, 2'h1, PB, 16'hffff, 1'b0, 1'b1);
        chk(512'(sga), 512'(PB));
        acc(1, 2'h0, PB, 16'h000f, 1'b0, 1'b1);
        chk(512'(fga[255:0]), 512'({PA[255:128], PB[127:0]}));
        acc(1, 2'h0, PA, 16'hffff, 1'b1, 1'b1);
        chk(512'(fga[255:0]), 512'({PA[255:128], PB[127:0]}));
        acc(1, 2'h0, PA, 16'hffff, 1'b0, 1'b0);
        chk(512'(fga[255:0]), 512'({PA[255:128], PB[127:0]}));
        acc(3, 2'h0, PA, 16'hffff, 1'b0, 1'b1);
        chk(512'(fga[255:0]), 512'({PA[255:128], PB[127:0]}));
        acc(8, 2'h0, PA, 16'hffff, 1'b0, 1'b1);
        chk(512'(fga[255:0]), 512'({PA[255:128], PB[127:0]}));
        acc(0, 2'h0, PA, 16'hffff, 1'b0, 1'b1);
        chk(512'(fga[255:0]), 512'(PA));
        acc(4, 2'h0, PA, 16'hffff, 1'b0, 1'b1);
        chk(512'(fga[127:0]), 512'h22222222_ffffffff_81111111);
        acc(5, 2'h0, PA, 16'hffff, 1'b0, 1'b1);
        chk(512'(fga[63:0]), 512'h81111111);
        acc(6, 2'h0, PA, 16'hffff, 1'b0, 1'b1);
        chk(512'(fga[65:0]), 512'({33'h1ffff8111, 33'h000001111}));
        acc(7, 2'h0, PA, 16'hffff, 1'b0, 1'b1);
        chk(512'(fga[65:0]), 512'({33'h000008111, 33'h000001111}));
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            special_wr <= 1'b1;
            special_index <= 3'(i);
            special_wdata <= wd(i, 1'b0);
        end
        @(posedge clk);
        special_wr <= 1'b0;
        // selector 8 must store nothing; pass 9 is outside four-component
        for (int s = 1; s < 10; s++) begin
            @(posedge clk);
            special_implicit_wr <= 1'b1;
            special_selector <= 8'(s == 9 ? 1 : s);
            implicit_data <= wd(s == 8 ? 5 : (s == 9 ? 2 : 7 - s), 1'b0);
            issue.send(0, arc_pkg::ARC_T_FLOAT, 2'h0, 1'b0, 1'(s < 9));
            special_implicit_wr <= 1'b0;
        end
        for (int i = 0; i < 8; i++)
            sp_rd(i, wd(i == 0 ? 0 : 7 - i, 1'b1));
        stop_test();
    end
endmodule // tb_top
